/* File: shared/hpc_consts.svh */
// constants for the haptic playback power control block
`ifndef HPC_CONSTS_SVH
`define HPC_CONSTS_SVH
`define HPC_ADR_CTRL    8'h00
`define HPC_ADR_STAT    8'h04
`define HPC_ADR_MASK    8'h08
`define HPC_ADR_STATE   8'h0c
`define HPC_IDX_FIFO    8'h0b
`define HPC_CTRL_RST    6'h01
`define HPC_CB_SRST     1
`define HPC_CLK_HZ      125000000
`define HPC_FS_HZ       8000
`define HPC_STARTUP_MS  2
`define HPC_TIMEOUT_SMP 8
`define HPC_FIFO_DEPTH  100
`define HPC_DAC_MID     8'h00
`endif

/* File: shared/hpc_pkg.sv */
// types shared by the haptic playback power control block
package hpc_pkg;
  typedef enum logic [2:0] {
    ST_STBY, ST_IDLE, ST_WAKE, ST_PLAY, ST_WAIT, ST_RAMP
  } hpc_state_t;
  // control register layout, bit 5 first
  typedef struct packed {
    logic [1:0] gain;
    logic       analog_input_select;
    logic       force_power_on;
    logic       soft_reset_bit;
    logic       standby;
  } hpc_ctrl_t;
  // sticky event layout shared by status and mask
  typedef struct packed {
    logic hot;
    logic ramp;
    logic underrun;
    logic fifo_full;
  } hpc_evt_t;
endpackage

/* File: rtl/hpc_top.sv */
// haptic playback power sequencer with wishbone register slave
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`include "hpc_consts.svh"
module hpc_top
  import hpc_pkg::*;
#(
  parameter int unsigned WAKE_CYC    = `HPC_STARTUP_MS * (`HPC_CLK_HZ / 1000),
  parameter int unsigned SAMPLE_CYC  = `HPC_CLK_HZ / `HPC_FS_HZ,
  parameter int unsigned TIMEOUT_SMP = `HPC_TIMEOUT_SMP,
  parameter int unsigned DEPTH       = `HPC_FIFO_DEPTH
)(
  input  wire logic        i_ref_clk,   // 125 MHz
  input  wire logic        i_rst,       // sync, active high
  input  wire logic        i_wb_cyc,    // bus cycle
  input  wire logic        i_wb_stb,    // strobe
  input  wire logic        i_wb_we,     // write
  input  wire logic [7:0]  i_wb_adr,    // byte address
  input  wire logic [31:0] i_wb_dat,    // write data
  input  wire logic [3:0]  i_wb_sel,    // byte lanes
  output logic      [31:0] o_wb_dat,    // read data
  output logic             o_wb_ack,    // ack
  output logic             o_wb_err,    // refused fifo write
  input  wire logic        i_over_temp, // async thermal flag
  input  wire logic        i_brownout,  // async brownout flag
  output logic             o_boost_en,  // boost converter enable
  output logic             o_amp_en,    // amplifier enable
  output logic             o_analog_sel,// amplifier input select
  output logic      [1:0]  o_gain,      // gain code
  output logic      [7:0]  o_dac_code,  // signed dac code
  output logic             o_irq        // level interrupt
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [1:0]    ot_sync_q, bo_sync_q;
  logic          ot_prev_q, srst_q, en_q, warm_q;
  hpc_ctrl_t     ctrl_q;
  hpc_evt_t      stat_q, mask_q, evt;
  hpc_state_t    st_q;
  logic [7:0]    dac_q;
  logic [7:0]    mem [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [CW-1:0] cnt_q;
  logic [31:0]   smp_q, wake_q, to_q, rdat_q;
  logic          ack_q, err_q;

  // wrap a fifo pointer at the depth
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // two stages before any use of the asynchronous flags
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ot_sync_q <= '0;
      bo_sync_q <= '0;
    end else begin
      ot_sync_q <= {ot_sync_q[0], i_over_temp};
      bo_sync_q <= {bo_sync_q[0], i_brownout};
    end
  end
  wire ot_s = ot_sync_q[1];

  // brownout and soft reset share the core reset path
  wire rst_core = i_rst | bo_sync_q[1] | srst_q;

  // bus decode; one request per cycle until answered
  wire req      = i_wb_cyc & i_wb_stb & ~ack_q & ~err_q;
  wire wr       = req & i_wb_we;
  wire rd       = req & ~i_wb_we;
  wire hit_ctrl = i_wb_adr == `HPC_ADR_CTRL;
  wire hit_stat = i_wb_adr == `HPC_ADR_STAT;
  wire hit_mask = i_wb_adr == `HPC_ADR_MASK;
  wire hit_st   = i_wb_adr == `HPC_ADR_STATE;
  wire hit_fifo = i_wb_adr == 8'({`HPC_IDX_FIFO, 2'b00});
  wire fifo_wr  = wr & hit_fifo & i_wb_sel[0];
  wire full     = cnt_q == CW'(DEPTH);
  // standby and ramp-down swallow samples without storing them
  wire drop     = (st_q == ST_STBY) | (st_q == ST_RAMP);
  wire push     = fifo_wr & ~full & ~drop;
  wire nak      = fifo_wr & full & ~drop;
  wire tick     = smp_q == SAMPLE_CYC - 1;
  wire pop      = tick & ~ot_s & (st_q == ST_PLAY) & (cnt_q != '0);
  wire wake_end = (st_q == ST_WAKE) & ~ot_s & (wake_q == WAKE_CYC - 1);

  // soft reset is a one-cycle pulse that ends once ack_q blocks the request
  always_ff @(posedge i_ref_clk) begin
    if (i_rst | bo_sync_q[1]) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= wr & hit_ctrl & i_wb_sel[0] & i_wb_dat[`HPC_CB_SRST];
    end
  end

  // answer one cycle after the request; a full fifo answers with err except in standby and ramp-down
  always_ff @(posedge i_ref_clk) begin
    if (rst_core) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= req & ~nak;
      err_q <= nak;
    end
  end
  assign o_wb_ack = ack_q;
  assign o_wb_err = err_q;

  // read mux; unmapped addresses read zero
  always_ff @(posedge i_ref_clk) begin
    if (rst_core) begin
      rdat_q <= '0;
    end else if (rd) begin
      unique case (1'b1)
        hit_ctrl: rdat_q <= 32'(ctrl_q);
        hit_stat: rdat_q <= 32'(stat_q);
        hit_mask: rdat_q <= 32'(mask_q);
        hit_st:   rdat_q <= 32'({cnt_q, 3'(st_q), en_q, ot_s});
        default:  rdat_q <= '0;
      endcase
    end
  end
  assign o_wb_dat = rdat_q;

  // control register; soft reset bit is never stored
  always_ff @(posedge i_ref_clk) begin
    if (rst_core) begin
      ctrl_q <= hpc_ctrl_t'(`HPC_CTRL_RST);
    end else if (wr & hit_ctrl & i_wb_sel[0]) begin
      ctrl_q <= hpc_ctrl_t'(i_wb_dat[5:0] & 6'h3d);
    end
  end
  assign o_gain       = ctrl_q.gain;
  assign o_analog_sel = ctrl_q.analog_input_select;

  // interrupt mask
  always_ff @(posedge i_ref_clk) begin
    if (rst_core) begin
      mask_q <= '0;
    end else if (wr & hit_mask & i_wb_sel[0]) begin
      mask_q <= hpc_evt_t'(i_wb_dat[3:0]);
    end
  end

  // event sources
  always_comb begin
    evt           = '0;
    evt.fifo_full = nak | (push & (cnt_q == CW'(DEPTH - 1)));
    evt.underrun  = (st_q == ST_PLAY) & tick & ~ot_s & (cnt_q == '0)
                    & ~ctrl_q.force_power_on;
    evt.ramp      = (st_q == ST_WAIT) & tick & (to_q == TIMEOUT_SMP - 1)
                    & (cnt_q == '0) & (dac_q != `HPC_DAC_MID);
    evt.hot       = ot_s & ~ot_prev_q;
  end

  // sticky status, read clears; a new event beats the clear
  always_ff @(posedge i_ref_clk) begin
    if (rst_core) begin
      stat_q    <= '0;
      ot_prev_q <= 1'b0;
    end else begin
      stat_q    <= (stat_q & ~{4{rd & hit_stat}}) | evt;
      ot_prev_q <= ot_s;
    end
  end
  assign o_irq = |(stat_q & mask_q);

  // fifo storage; the array keeps no reset
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wp_q] <= i_wb_dat[7:0];
    end
  end

  // fifo pointers and fill level
  always_ff @(posedge i_ref_clk) begin
    if (rst_core) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= ptr_inc(wp_q);
      if (pop)  rp_q <= ptr_inc(rp_q);
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end

  // free-running sample clock at the playback rate
  always_ff @(posedge i_ref_clk) begin
    if (rst_core | tick) begin
      smp_q <= '0;
    end else begin
      smp_q <= smp_q + 1;
    end
  end

  // power sequencer; standby overrides every other state
  always_ff @(posedge i_ref_clk) begin
    if (rst_core) begin
      st_q   <= ST_STBY;
      wake_q <= '0;
      to_q   <= '0;
    end else if (ctrl_q.standby) begin
      st_q <= ST_STBY;
    end else begin
      unique case (st_q)
        ST_STBY: st_q <= ST_IDLE;
        ST_IDLE: begin
          wake_q <= '0;
          if ((cnt_q != '0) | ctrl_q.force_power_on) begin
            st_q <= warm_q ? ST_PLAY : ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (!ot_s) wake_q <= wake_q + 1;
          if (wake_end) st_q <= ST_PLAY;
        end
        ST_PLAY: begin
          to_q <= '0;
          if (evt.underrun) st_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (cnt_q != '0) begin
            st_q <= ST_PLAY;
          end else if (tick) begin
            to_q <= to_q + 1;
            if (to_q == TIMEOUT_SMP - 1) begin
              st_q <= evt.ramp ? ST_RAMP : ST_IDLE;
            end
          end
        end
        ST_RAMP: if (dac_q == `HPC_DAC_MID) st_q <= ST_IDLE;
      endcase
    end
  end

  // once warm under force, later samples skip the wake-up count
  always_ff @(posedge i_ref_clk) begin
    if (rst_core) begin
      warm_q <= 1'b0;
    end else begin
      warm_q <= ctrl_q.force_power_on & ~ctrl_q.standby & (warm_q | wake_end);
    end
  end

  // dac code; ramp walks one lsb per sample toward mid-scale
  always_ff @(posedge i_ref_clk) begin
    if (rst_core | (st_q == ST_STBY)) begin
      dac_q <= `HPC_DAC_MID;
    end else if (pop) begin
      dac_q <= mem[rp_q];
    end else if ((st_q == ST_RAMP) & tick & ~ot_s & (dac_q != `HPC_DAC_MID)) begin
      dac_q <= dac_q[7] ? dac_q + 8'h01 : dac_q - 8'h01;
    end
  end
  assign o_dac_code = dac_q;

  // power enables; a limitation is that analog mode never self-wakes
  wire pw = (st_q != ST_STBY) & (st_q != ST_IDLE);
  always_ff @(posedge i_ref_clk) begin
    if (rst_core) begin
      en_q <= 1'b0;
    end else begin
      en_q <= ~ctrl_q.standby & ~ot_s & (ctrl_q.force_power_on
              | (~ctrl_q.analog_input_select & pw));
    end
  end
  assign o_boost_en = en_q;
  assign o_amp_en   = en_q;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (rst_core);

  sequence s_wake_done;
    (st_q == ST_WAKE) ##1 (st_q == ST_PLAY);
  endsequence

  standby_power_a: assert property (ctrl_q.standby |=> !o_boost_en && !o_amp_en)
    else $error("power enabled in standby");
  thermal_off_a: assert property (ot_s |=> !o_boost_en && !o_amp_en)
    else $error("power enabled while hot");
  wake_length_a: assert property (s_wake_done |-> $past(wake_q) == WAKE_CYC - 1)
    else $error("wake-up ended early");
  ramp_drop_a: assert property ((st_q == ST_RAMP) && fifo_wr |=> cnt_q == $past(cnt_q))
    else $error("sample stored during ramp");
  full_refuse_a: assert property (fifo_wr && full && !drop |=> o_wb_err && !o_wb_ack
    ##1 stat_q.fifo_full)
    else $error("full fifo write not refused");
  ramp_step_a: assert property ((st_q == ST_RAMP) && tick && !ot_s && dac_q == 8'h05
    |=> dac_q == 8'h04)
    else $error("ramp step wrong");
  // standby outranks the underrun move, so it is left out of the trigger
  underrun_wait_a: assert property (evt.underrun && !ctrl_q.standby |=> st_q == ST_WAIT)
    else $error("underrun not handled");
  analog_gate_a: assert property (ctrl_q.analog_input_select && !ctrl_q.force_power_on
    |=> !o_boost_en)
    else $error("analog mode powered without force");
  // idle without force keeps both rails off
  idle_power_a: assert property ((st_q == ST_IDLE) && !ctrl_q.force_power_on
    |=> !o_boost_en && !o_amp_en)
    else $error("power enabled while idle");
  // soft reset raises rst_core itself, so only the outer resets may disable this check
  soft_reset_a: assert property (disable iff (i_rst || bo_sync_q[1])
    wr && hit_ctrl && i_wb_sel[0] && i_wb_dat[`HPC_CB_SRST]
    |=> ##1 ctrl_q.standby && st_q == ST_STBY)
    else $error("soft reset did not reach standby");
endmodule

/* File: testbench/hpc_host.sv */
// wishbone host model standing in for the far-side bus master
module hpc_host (
  input  wire logic        i_ref_clk, // block clock
  input  wire logic        i_ack,     // slave accept
  input  wire logic        i_err,     // slave refusal
  output logic             o_cyc,     // cyc and stb together
  output logic             o_we,      // write when high
  output logic      [7:0]  o_adr,     // byte address
  output logic      [31:0] o_dat      // write data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {o_cyc, o_we, o_adr, o_dat} = '0;
  // one classic cycle; everything held until ack or err is sampled high
  // no cycle limit here: only the bench watchdog may end a stalled wait
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic refused);
    @(posedge i_ref_clk);
    o_cyc <= 1'b1;
    o_we  <= we;
    o_adr <= adr;
    o_dat <= dat;
    @(posedge i_ref_clk);
    while (!(i_ack === 1'b1 || i_err === 1'b1)) begin
      @(posedge i_ref_clk);
    end
    refused = (i_err === 1'b1);
    o_cyc <= 1'b0;
    o_we  <= 1'b0;
    // the idle cycle keeps a new request off the answering edge
    @(posedge i_ref_clk);
  endtask
endmodule

/* File: testbench/test_haptic_playback_power_control.sv */
// self-checking bench for the haptic playback power sequencer
`include "hpc_consts.svh"
module test_haptic_playback_power_control import hpc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_ref_clk = 1'b0;
  logic        i_rst     = 1'b1;
  logic        i_over_temp = 1'b0;
  logic        i_brownout  = 1'b0;
  logic        cyc, we, ack, err, boost_en, amp_en, asel, irq, refused;
  logic [7:0]  adr, dac, v;
  logic [31:0] wdat, rdat;
  logic [1:0]  gain;
  logic [31:0] exp_q[$], msk_q[$];
  int          err_count = 0;
  int          compares  = 0;
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end
`define WAITC(c) for (int k = 0; k < 3000 && !(c); k++) @(posedge i_ref_clk);

  always #4 i_ref_clk = ~i_ref_clk;

  // shortened counts keep the run brief
  hpc_top #(.WAKE_CYC(50), .SAMPLE_CYC(8), .TIMEOUT_SMP(2), .DEPTH(4)) dut_u (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(cyc),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf),
    .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(err), .i_over_temp(i_over_temp),
    .i_brownout(i_brownout), .o_boost_en(boost_en), .o_amp_en(amp_en),
    .o_analog_sel(asel), .o_gain(gain), .o_dac_code(dac), .o_irq(irq));
  hpc_host host_u (.i_ref_clk(i_ref_clk), .i_ack(ack), .i_err(err), .o_cyc(cyc),
    .o_we(we), .o_adr(adr), .o_dat(wdat));

  // each read answer is taken against the oldest noted expectation
  always @(posedge i_ref_clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      `CHK(rdat & msk_q[0], exp_q[0] & msk_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, refused);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    host_u.xfer(1'b0, a, 32'h0, refused);
  endtask
  task automatic give_verdict;
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog sized well beyond the longest ramp and wake sequence
  initial begin
    #400000;
    err_count++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h7773));
    v = 8'(8 + $urandom_range(19));
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rd(`HPC_ADR_CTRL, 32'h01, 32'h3f);
    rd(`HPC_ADR_STATE, 32'h0, 32'h1c);
    wr(`HPC_ADR_MASK, 32'h1);
    wr(`HPC_ADR_CTRL, 32'h0);
    rd(`HPC_ADR_STATE, 32'h4, 32'h1c);
    `CHK(boost_en, 1'b0)
    // five bytes into a four-deep fifo while still waking
    for (int i = 0; i < 5; i++) wr(8'h2c, {24'h0, v});
    `CHK(refused, 1'b1)
    `CHK(irq, 1'b1)
    `CHK({boost_en, amp_en}, 2'b11)
    `CHK(dac, `HPC_DAC_MID)
    rd(`HPC_ADR_STAT, 32'h1, 32'h1);
    `CHK(irq, 1'b0)
    `WAITC(dac === v)
    `CHK(dac, v)
    wr(8'h2c, {24'h0, v});
    `CHK(refused, 1'b0)
    `WAITC(dac === v - 8'h1)
    `CHK(dac, v - 8'h1)
    wr(8'h2c, 32'h55);
    rd(`HPC_ADR_STATE, 32'h14, 32'hffc);
    `WAITC(boost_en === 1'b0)
    `CHK(dac, `HPC_DAC_MID)
    rd(`HPC_ADR_STATE, 32'h4, 32'hffc);
    for (int g = 0; g < 4; g++) begin
      wr(`HPC_ADR_CTRL, 32'(g << 4) | 32'h0c);
      `CHK(gain, 2'(g))
    end
    `CHK(asel, 1'b1)
    `CHK(boost_en, 1'b1)
    i_over_temp <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
    `CHK(boost_en, 1'b0)
    rd(`HPC_ADR_STAT, 32'h8, 32'h8);
    i_over_temp <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    `CHK(boost_en, 1'b1)
    wr(`HPC_ADR_CTRL, 32'h08);
    repeat (3) @(posedge i_ref_clk);
    `CHK(boost_en, 1'b0)
    wr(`HPC_ADR_CTRL, 32'h01);
    wr(8'h2c, {24'h0, v});
    rd(`HPC_ADR_STATE, 32'h0, 32'hffc);
    wr(`HPC_ADR_CTRL, 32'h36);
    repeat (2) @(posedge i_ref_clk);
    rd(`HPC_ADR_CTRL, 32'h01, 32'h3f);
    wr(`HPC_ADR_CTRL, 32'h34);
    i_brownout <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    `CHK({gain, boost_en}, 3'b000)
    i_brownout <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    rd(`HPC_ADR_CTRL, 32'h01, 32'h3f);
    rd(8'h40, 32'h0, 32'hffffffff);
    repeat (4) @(posedge i_ref_clk);
    give_verdict();
  end
endmodule
